/* rtl/mia_pkg.sv */
// Package with the constants and types of the indirect extended register window.
package mia_pkg;

   localparam int DATA_W = 16;
   localparam int MGMT_ADDR_W = 5;
   localparam int DEV_W = 5;

   // Direct management register offsets.
   localparam logic [4:0] REG_ACCESS_CTRL = 5'h0D;
   localparam logic [4:0] REG_ADDR_DATA = 5'h0E;

   // Field positions of the access-control register.
   localparam int FN_MSB = 15;
   localparam int FN_LSB = 14;
   localparam int DEV_MSB = 4;
   localparam int DEV_LSB = 0;

   // Values after reset, the address step and the value returned by an ignored read.
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
   localparam logic [15:0] READ_IGNORED = 16'h0000;

   // Function codes.
   localparam logic [1:0] FN_ADDRESS = 2'h0;
   localparam logic [1:0] FN_DATA = 2'h1;
   localparam logic [1:0] FN_DATA_INC = 2'h2;
   localparam logic [1:0] FN_DATA_INC_WR = 2'h3;

   // Supported device selects.
   localparam logic [4:0] DEV_VENDOR = 5'h1F;
   localparam logic [4:0] DEV_EEE3 = 5'h03;
   localparam logic [4:0] DEV_EEE7 = 5'h07;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h1,
      ST_EXT = 3'h2,
      ST_DONE = 3'h4
   } mia_state_t;

   // True for a device select that the window serves.
   function automatic logic dev_supported(input logic [4:0] dev);
      dev_supported = (dev == DEV_VENDOR) || (dev == DEV_EEE3) ||
         (dev == DEV_EEE7);
   endfunction

   // True when an indirect access would land on the window's own registers.
   function automatic logic self_target(input logic [4:0] dev,
                                        input logic [15:0] addr);
      self_target = (dev == DEV_VENDOR) &&
         ((addr == {11'h000, REG_ACCESS_CTRL}) ||
          (addr == {11'h000, REG_ADDR_DATA}));
   endfunction

endpackage

/* rtl/mia_ext_addr.sv */
// Internal extended address register with load and post-increment.
module mia_ext_addr
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Control.
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic inc,
   // State.
   output logic [15:0] addr
);

   logic [15:0] addr_reg;
   logic [15:0] addr_next;

   // The value is held between operations; the sum is cut to 16 bits so the
   // top address wraps to zero.
   always_comb
   begin
      addr_next = addr_reg;
      if (load)
      begin
         addr_next = load_value;
      end
      else if (inc)
      begin
         addr_next = 16'(addr_reg + mia_pkg::ADDR_STEP);
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         addr_reg <= mia_pkg::ADDR_RESET;
      end
      else
      begin
         addr_reg <= addr_next;
      end
   end

   assign addr = addr_reg;

endmodule

/* rtl/mia_top.sv */
// Indirect access window from direct management registers to extended space.
//
// Behaviour
// - Access control at register 0x0D, address/data at 0x0E, both direct.
// - Control bits 15:14 select address, data, data+increment, write-increment.
// - Function 00: address/data write loads the internal extended address.
// - Function 01: address/data write updates the addressed extended register.
// - Function 01: repeated writes hit the same register, address unchanged.
// - Function 01: address/data read returns the addressed extended register.
// - Function 01: repeated reads return the same register, address unchanged.
// - Internal address holds its value between operations.
// - Functions 10 and 11: each data write then increments the address.
// - Function 10: each data read then increments the address.
// - Control bits 4:0 select the target device, for example device 7.
// - Indirect accesses to the window's own two registers are ignored.
// - Only device selects 31, 3 and 7 are served; others ignored.
// - Function 11: reads leave the internal address unchanged.
module mia_top
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Direct management register port.
   input wire logic mgmt_req,
   input wire logic mgmt_we,
   input wire logic [4:0] mgmt_addr,
   input wire logic [15:0] mgmt_wdata,
   output logic mgmt_ack,
   output logic mgmt_busy,
   output logic [15:0] mgmt_rdata,
   // Extended register space port.
   output logic ext_req,
   output logic ext_we,
   output logic [4:0] ext_dev,
   output logic [15:0] ext_addr,
   output logic [15:0] ext_wdata,
   input wire logic [15:0] ext_rdata
);

   mia_pkg::mia_state_t state_reg;
   mia_pkg::mia_state_t state_next;
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic we_reg;
   logic we_next;
   logic [15:0] wdata_reg;
   logic [15:0] wdata_next;
   logic addr_load;
   logic addr_inc;
   logic [1:0] fn;
   logic dev_ok;
   logic take;

   assign fn = ctrl_reg[mia_pkg::FN_MSB:mia_pkg::FN_LSB];
   assign dev_ok = mia_pkg::dev_supported(
      ctrl_reg[mia_pkg::DEV_MSB:mia_pkg::DEV_LSB]);
   // Requests that arrive while a transfer is in flight are dropped.
   assign take = mgmt_req && (state_reg == mia_pkg::ST_IDLE);

   mia_ext_addr u_addr
   (
      .mclk(mclk),
      .rst_b(rst_b),
      .load(addr_load),
      .load_value(mgmt_wdata),
      .inc(addr_inc),
      .addr(ext_addr)
   );

   always_comb
   begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      rdata_next = rdata_reg;
      we_next = we_reg;
      wdata_next = wdata_reg;
      addr_load = 1'b0;
      addr_inc = 1'b0;
      unique case (state_reg)
         mia_pkg::ST_IDLE:
         begin
            if (take)
            begin
               state_next = mia_pkg::ST_DONE;
               rdata_next = mia_pkg::READ_IGNORED;
               if (mgmt_addr == mia_pkg::REG_ACCESS_CTRL)
               begin
                  if (mgmt_we)
                  begin
                     ctrl_next = mgmt_wdata;
                  end
                  else
                  begin
                     rdata_next = ctrl_reg;
                  end
               end
               else if (mgmt_addr == mia_pkg::REG_ADDR_DATA && dev_ok)
               begin
                  if (fn == mia_pkg::FN_ADDRESS)
                  begin
                     addr_load = mgmt_we;
                     rdata_next = mgmt_we ? mia_pkg::READ_IGNORED : ext_addr;
                  end
                  else if (!mia_pkg::self_target(ext_dev, ext_addr))
                  begin
                     state_next = mia_pkg::ST_EXT;
                     we_next = mgmt_we;
                     wdata_next = mgmt_wdata;
                  end
               end
            end
         end
         mia_pkg::ST_EXT:
         begin
            state_next = mia_pkg::ST_DONE;
            rdata_next = we_reg ? mia_pkg::READ_IGNORED : ext_rdata;
            // Function 01 never steps; 10 steps always; 11 only on writes.
            addr_inc = (fn == mia_pkg::FN_DATA_INC) ||
               ((fn == mia_pkg::FN_DATA_INC_WR) && we_reg);
         end
         mia_pkg::ST_DONE:
         begin
            state_next = mia_pkg::ST_IDLE;
         end
         default:
         begin
            state_next = mia_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= mia_pkg::ST_IDLE;
         ctrl_reg <= mia_pkg::CTRL_RESET;
         rdata_reg <= mia_pkg::RDATA_RESET;
         we_reg <= 1'b0;
         wdata_reg <= mia_pkg::RDATA_RESET;
      end
      else
      begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
         we_reg <= we_next;
         wdata_reg <= wdata_next;
      end
   end

   assign mgmt_ack = (state_reg == mia_pkg::ST_DONE);
   assign mgmt_busy = (state_reg != mia_pkg::ST_IDLE);
   assign mgmt_rdata = rdata_reg;
   assign ext_req = (state_reg == mia_pkg::ST_EXT);
   assign ext_we = we_reg;
   assign ext_wdata = wdata_reg;
   assign ext_dev = ctrl_reg[mia_pkg::DEV_MSB:mia_pkg::DEV_LSB];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_data_take;
      take && mgmt_addr == mia_pkg::REG_ADDR_DATA && dev_ok &&
         fn != mia_pkg::FN_ADDRESS && !mia_pkg::self_target(ext_dev, ext_addr);
   endsequence

   sequence s_ext_then_ack;
      ext_req ##1 mgmt_ack;
   endsequence

   property p_ctrl_direct;
      take && mgmt_we && mgmt_addr == mia_pkg::REG_ACCESS_CTRL |=>
         mgmt_ack && ctrl_reg == $past(mgmt_wdata);
   endproperty
   a_ctrl_direct: assert property (p_ctrl_direct)
      else $error("Control write not stored with acknowledge.");

   property p_addr_load;
      take && mgmt_we && mgmt_addr == mia_pkg::REG_ADDR_DATA && dev_ok &&
         fn == mia_pkg::FN_ADDRESS |=> ext_addr == $past(mgmt_wdata) && !ext_req;
   endproperty
   a_addr_load: assert property (p_addr_load)
      else $error("Address function did not load the internal address.");

   property p_data_write;
      s_data_take and mgmt_we |=> ext_req && ext_we &&
         ext_wdata == $past(mgmt_wdata) ##1 mgmt_ack;
   endproperty
   a_data_write: assert property (p_data_write)
      else $error("Data write did not reach the extended register.");

   property p_read_return;
      s_data_take and !mgmt_we |=> s_ext_then_ack ##0
         mgmt_rdata == $past(ext_rdata);
   endproperty
   a_read_return: assert property (p_read_return)
      else $error("Data read did not return the extended register.");

   property p_no_step;
      ext_req && fn == mia_pkg::FN_DATA |=> ext_addr == $past(ext_addr);
   endproperty
   a_no_step: assert property (p_no_step)
      else $error("Function 01 changed the internal address.");

   property p_step;
      ext_req && (fn == mia_pkg::FN_DATA_INC || (ext_we && fn[1])) |=>
         ext_addr == 16'($past(ext_addr) + mia_pkg::ADDR_STEP);
   endproperty
   a_step: assert property (p_step)
      else $error("Post-increment did not advance the internal address.");

   property p_wr_only_step;
      ext_req && !ext_we && fn == mia_pkg::FN_DATA_INC_WR |=> $stable(ext_addr);
   endproperty
   a_wr_only_step: assert property (p_wr_only_step)
      else $error("Function 11 read changed the internal address.");

   property p_ignore;
      take && mgmt_addr == mia_pkg::REG_ADDR_DATA && (!dev_ok ||
         (fn != mia_pkg::FN_ADDRESS && mia_pkg::self_target(ext_dev, ext_addr)))
         |=> mgmt_ack && !ext_req && $stable(ext_addr) &&
         mgmt_rdata == mia_pkg::READ_IGNORED;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("Ignored access reached the extended space.");

   property p_hold;
      !addr_load && !ext_req |=> $stable(ext_addr);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Internal address moved without an operation.");

   property p_dev_ok;
      ext_req |-> mia_pkg::dev_supported(ext_dev) && ext_dev == ctrl_reg[4:0];
   endproperty
   a_dev_ok: assert property (p_dev_ok)
      else $error("Extended access issued with an unsupported device.");

endmodule

/* tb/mia_ext_model.sv */
// Behavioural model of the extended register space behind the window.
module mia_ext_model
(
   // Clock.
   input wire logic mclk,
   // Extended register space port.
   input wire logic ext_req,
   input wire logic ext_we,
   input wire logic [4:0] ext_dev,
   input wire logic [15:0] ext_addr,
   input wire logic [15:0] ext_wdata,
   output logic [15:0] ext_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [int];
   logic [15:0] junk = 16'h5A5A;
   int n_wr = 0;
   int key;
   // Outside a request the data toggles, so a stale sample cannot match.
   always @*
   begin
      key = int'({ext_dev, ext_addr});
      if (ext_req !== 1'b1)
         ext_rdata = junk;
      else if (mem.exists(key))
         ext_rdata = mem[key];
      else
         ext_rdata = 16'hA5A5 ^ ext_addr;
   end
   always @(posedge mclk)
   begin
      junk <= ~junk;
      if (ext_req === 1'b1 && ext_we === 1'b1)
      begin
         mem[key] = ext_wdata;
         n_wr++;
      end
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the indirect extended register window.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic mgmt_req = 1'b0;
   logic mgmt_we = 1'b0;
   logic [4:0] mgmt_addr = 5'h00;
   logic [15:0] mgmt_wdata = 16'h0000;
   logic mgmt_ack, mgmt_busy, ext_req, ext_we;
   logic [15:0] mgmt_rdata, ext_addr, ext_wdata, ext_rdata;
   logic [4:0] ext_dev;
   int mismatches = 0;
   int num_checks = 0;
   always #2 mclk = ~mclk;
   mia_top u_mia_top (.mclk(mclk), .rst_b(rst_b), .mgmt_req(mgmt_req),
      .mgmt_we(mgmt_we), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
      .mgmt_ack(mgmt_ack), .mgmt_busy(mgmt_busy), .mgmt_rdata(mgmt_rdata),
      .ext_req(ext_req), .ext_we(ext_we), .ext_dev(ext_dev),
      .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
   mia_ext_model u_mia_ext_model (.mclk(mclk), .ext_req(ext_req),
      .ext_we(ext_we), .ext_dev(ext_dev), .ext_addr(ext_addr),
      .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, q);
      num_checks++;
      if (q !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, q);
      end
   endtask
   // One direct access; the pulse is one cycle and ack is bounded.
   task automatic mg(input logic we, input logic [4:0] a,
                     input logic [15:0] d, output logic [15:0] q);
      int i;
      @(posedge mclk);
      mgmt_req <= 1'b1;
      mgmt_we <= we;
      mgmt_addr <= a;
      mgmt_wdata <= d;
      @(posedge mclk);
      mgmt_req <= 1'b0;
      i = 0;
      do
      begin
         @(negedge mclk);
         i++;
      end
      while (mgmt_ack !== 1'b1 && i < 5);
      if (mgmt_ack !== 1'b1)
      begin
         mismatches++;
         $display("unexpected ack timeout expected 1 seen %b", mgmt_ack);
         report_and_stop();
      end
      q = mgmt_rdata;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      mg(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      mg(1'b0, a, 16'h0000, q);
      chk($sformatf("read %h", a), e, q);
   endtask
   function automatic logic [15:0] mv(input logic [20:0] k);
      mv = u_mia_ext_model.mem.exists(int'(k)) ?
         u_mia_ext_model.mem[int'(k)] : 16'hXXXX;
   endfunction
   task automatic t_reset();
      rdc(5'h0D, 16'h0000);
      rdc(5'h0E, 16'h0000);
      rdc(5'h03, 16'h0000);
   endtask
   task automatic t_plain_write();
      wr(5'h0D, 16'h001F);
      wr(5'h0E, 16'h0461);
      wr(5'h0D, 16'h401F);
      wr(5'h0E, 16'h0400);
      wr(5'h0E, 16'h0401);
      chk("ext reg", 16'h0401, mv({5'h1F, 16'h0461}));
      rdc(5'h0E, 16'h0401);
      wr(5'h0D, 16'h001F);
      rdc(5'h0E, 16'h0461);
   endtask
   task automatic t_dev7_read();
      wr(5'h0D, 16'h0007);
      wr(5'h0E, 16'h003D);
      wr(5'h0D, 16'h4007);
      rdc(5'h0E, 16'hA5A5 ^ 16'h003D);
      rdc(5'h0E, 16'hA5A5 ^ 16'h003D);
      wr(5'h0D, 16'h0007);
      rdc(5'h0E, 16'h003D);
   endtask
   task automatic t_post_inc();
      wr(5'h0D, 16'h001F);
      wr(5'h0E, 16'hFFFF);
      wr(5'h0D, 16'h801F);
      wr(5'h0E, 16'h1111);
      wr(5'h0E, 16'h2222);
      chk("top reg", 16'h1111, mv({5'h1F, 16'hFFFF}));
      chk("wrapped reg", 16'h2222, mv({5'h1F, 16'h0000}));
      rdc(5'h0E, 16'hA5A5 ^ 16'h0001);
      rdc(5'h0E, 16'hA5A5 ^ 16'h0002);
      wr(5'h0D, 16'hC01F);
      rdc(5'h0E, 16'hA5A5 ^ 16'h0003);
      rdc(5'h0E, 16'hA5A5 ^ 16'h0003);
      wr(5'h0E, 16'h3333);
      chk("inc reg", 16'h3333, mv({5'h1F, 16'h0003}));
      wr(5'h0D, 16'h001F);
      rdc(5'h0E, 16'h0004);
   endtask
   task automatic t_ignored();
      int n;
      n = u_mia_ext_model.n_wr;
      wr(5'h0D, 16'h4005);
      rdc(5'h0D, 16'h4005);
      wr(5'h0E, 16'h7777);
      rdc(5'h0E, 16'h0000);
      wr(5'h0D, 16'h001F);
      wr(5'h0E, 16'h000D);
      wr(5'h0D, 16'h401F);
      wr(5'h0E, 16'hBEEF);
      rdc(5'h0E, 16'h0000);
      chk("ext writes", 16'(n), 16'(u_mia_ext_model.n_wr));
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_plain_write();
      t_dev7_read();
      t_post_inc();
      t_ignored();
      report_and_stop();
   end
endmodule
